// ---- design/timer_compare_core.sv ----
// 16-bit timer/event counter core with two compare/capture channels
// assumes one 50 MHz clock, plain register port, pins from outside synchronised here
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ns
`include "timer_compare_defs.svh"
`default_nettype none
module timer_compare_core (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        timer_in_0,
  input  wire logic        timer_in_1,
  output logic             timer_out_0,
  output logic             timer_out_1,
  output logic             ext_trigger,
  output logic             match_irq_0,
  output logic             match_irq_1,
  output logic             irq
);
  // =====================================================
  // input synchronisers, filter and edge detection
  logic [1:0] s1_ff, s2_ff, s3_ff, flt_ff;
  logic [1:0] nxt_s1, nxt_s2, nxt_s3, nxt_flt;
  logic [1:0] cap_pulse, evt_pulse;
  logic [2:0] nfc_cnt_ff [2];
  logic [2:0] nxt_nfc_cnt [2];
  logic [15:0] ctrl0_ff, ctrl1_ff, outctl_ff, capedge_ff, evtedge_ff, nfc_ff;
  logic [15:0] ccr_ff [2];
  logic [15:0] shadow_ff [2];
  logic [15:0] count_ff;
  logic [2:0]  pre_ff;
  logic [9:0]  div_ff;
  logic [3:0]  status_ff, mask_ff;
  logic        started_ff;
  logic        run;
  assign run = ctrl0_ff[`CTRL0_RUN];

  always_comb begin
    nxt_s1 = {timer_in_1, timer_in_0};
    nxt_s2 = s1_ff;
    nxt_s3 = flt_ff;
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_in
      logic cap_mode;
      logic fin;
      timer_compare_pkg::edge_sel_t ce, ee;
      assign cap_mode = ctrl1_ff[`CTRL1_CAP0 + g];
      assign ce = timer_compare_pkg::edge_sel_t'(capedge_ff[2*g +: 2]);
      assign ee = timer_compare_pkg::edge_sel_t'(evtedge_ff[2*g +: 2]);
      // filter only in capture mode; length counts stable samples
      always_comb begin
        nxt_nfc_cnt[g] = 3'h0;
        nxt_flt[g] = flt_ff[g];
        if (!cap_mode || nfc_ff[4*g +: 3] == 3'h0) begin
          nxt_flt[g] = s2_ff[g];
        end else if (s2_ff[g] != flt_ff[g]) begin
          nxt_nfc_cnt[g] = nfc_cnt_ff[g] + 3'h1;
          if (nfc_cnt_ff[g] + 3'h1 >= nfc_ff[4*g +: 3]) begin
            nxt_flt[g] = s2_ff[g];
            nxt_nfc_cnt[g] = 3'h0;
          end
        end
      end
      assign fin = flt_ff[g] != s3_ff[g];
      // one pulse per valid edge
      assign cap_pulse[g] = run && fin &&
        ((flt_ff[g] && ce[0]) || (!flt_ff[g] && ce[1]));
      assign evt_pulse[g] = run && fin &&
        ((flt_ff[g] && ee[0]) || (!flt_ff[g] && ee[1]));
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          nfc_cnt_ff[g] <= 3'h0;
        end else begin
          nfc_cnt_ff[g] <= nxt_nfc_cnt[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_ff  <= 2'h0;
      s2_ff  <= 2'h0;
      s3_ff  <= 2'h0;
      flt_ff <= 2'h0;
    end else begin
      s1_ff  <= nxt_s1;
      s2_ff  <= nxt_s2;
      s3_ff  <= nxt_s3;
      flt_ff <= nxt_flt;
    end
  end

  // =====================================================
  // prescaler and count source selector
  logic [9:0]  nxt_div;
  logic        tick;
  logic        int_tick;
  always_comb begin
    nxt_div = run ? div_ff + 10'h1 : 10'h0;
    // a tap fires when the low bits are all ones; divisors 1,2,4,8,16,64,256,1024
    case (pre_ff)
      3'h0:    int_tick = 1'b1;
      3'h1:    int_tick = div_ff[0];
      3'h2:    int_tick = &div_ff[1:0];
      3'h3:    int_tick = &div_ff[2:0];
      3'h4:    int_tick = &div_ff[3:0];
      3'h5:    int_tick = &div_ff[5:0];
      3'h6:    int_tick = &div_ff[7:0];
      default: int_tick = &div_ff[9:0];
    endcase
    // pin 0 doubles as event input
    tick = ctrl1_ff[`CTRL1_EXT] ? evt_pulse[0] : int_tick;
  end

  // =====================================================
  // counter, compare and capture
  logic [15:0] nxt_count;
  logic        nxt_started;
  logic [3:0]  ev;
  always_comb begin
    nxt_count = count_ff;
    nxt_started = started_ff;
    if (!run) begin
      nxt_count = `CNT_HOLD;
      nxt_started = 1'b0;
    end else if (tick) begin
      nxt_count = count_ff + 16'h1;  // all ones wraps to zero first
      nxt_started = 1'b1;
    end
    // match only on a live count, not on the held all-ones value
    ev[`ST_MATCH0] = run && started_ff && tick && count_ff + 16'h1 == shadow_ff[0];
    ev[`ST_MATCH1] = run && started_ff && tick && count_ff + 16'h1 == shadow_ff[1];
    if (run && !started_ff && tick) begin
      ev[`ST_MATCH0] = shadow_ff[0] == 16'h0;
      ev[`ST_MATCH1] = shadow_ff[1] == 16'h0;
    end
    ev[`ST_CAP0] = cap_pulse[0] && ctrl1_ff[`CTRL1_CAP0];
    ev[`ST_CAP1] = cap_pulse[1] && ctrl1_ff[`CTRL1_CAP1];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_ff   <= `CNT_HOLD;
      started_ff <= 1'b0;
      div_ff     <= 10'h0;
    end else begin
      count_ff   <= nxt_count;
      started_ff <= nxt_started;
      div_ff     <= nxt_div;
    end
  end

  // =====================================================
  // register file, shadows, outputs
  logic [15:0] nxt_ctrl0, nxt_ctrl1, nxt_outctl, nxt_capedge, nxt_evtedge, nxt_nfc;
  logic [15:0] nxt_ccr [2];
  logic [15:0] nxt_shadow [2];
  logic [15:0] nxt_rdata;
  logic [3:0]  nxt_status, nxt_mask;
  logic [1:0]  nxt_tout;
  logic        nxt_trig;
  always_comb begin
    nxt_ctrl0 = ctrl0_ff;
    nxt_ctrl1 = ctrl1_ff;
    nxt_outctl = outctl_ff;
    nxt_capedge = capedge_ff;
    nxt_evtedge = evtedge_ff;
    nxt_nfc = nfc_ff;
    nxt_mask = mask_ff;
    nxt_ccr = ccr_ff;
    nxt_shadow = shadow_ff;
    nxt_status = status_ff;
    if (wr) begin
      case (addr)
        `OFF_CTRL0:   nxt_ctrl0 = wdata & 16'h0087;
        `OFF_CTRL1:   nxt_ctrl1 = wdata & 16'h0007;
        `OFF_OUTCTL:  nxt_outctl = wdata & 16'h000f;
        `OFF_CAPEDGE: nxt_capedge = wdata & 16'h000f;
        `OFF_EVTEDGE: nxt_evtedge = wdata & 16'h000f;
        `OFF_NFC:     nxt_nfc = wdata & 16'h0077;
        `OFF_CCR0:    nxt_ccr[0] = wdata;
        `OFF_CCR1:    nxt_ccr[1] = wdata;
        `OFF_STATUS:  nxt_status = status_ff & ~wdata[3:0];
        `OFF_MASK:    nxt_mask = wdata[3:0];
        default:      nxt_mask = mask_ff;
      endcase
    end
    for (int i = 0; i < 2; i++) begin
      // compare mode: write copies into shadow
      if (wr && addr == (i == 0 ? `OFF_CCR0 : `OFF_CCR1) &&
          !ctrl1_ff[`CTRL1_CAP0 + i]) begin
        nxt_shadow[i] = wdata;
      end
      if (cap_pulse[i] && ctrl1_ff[`CTRL1_CAP0 + i]) begin
        nxt_ccr[i] = run ? count_ff : `CNT_READ_OFF;
      end
    end
    nxt_status = nxt_status | ev;  // set wins over clear
    // outputs toggle on match when enabled, level inverted by polarity
    nxt_tout = {timer_out_1, timer_out_0};
    for (int i = 0; i < 2; i++) begin
      if (!run) begin
        nxt_tout[i] = outctl_ff[2*i+1];
      end else if (outctl_ff[2*i] && ev[i]) begin
        nxt_tout[i] = ~nxt_tout[i];
      end
    end
    nxt_trig = evt_pulse[0] && !ctrl1_ff[`CTRL1_EXT];
    nxt_rdata = 16'h0;
    if (rd) begin
      case (addr)
        `OFF_CTRL0:   nxt_rdata = ctrl0_ff;
        `OFF_CTRL1:   nxt_rdata = ctrl1_ff;
        `OFF_OUTCTL:  nxt_rdata = outctl_ff;
        `OFF_CAPEDGE: nxt_rdata = capedge_ff;
        `OFF_EVTEDGE: nxt_rdata = evtedge_ff;
        `OFF_NFC:     nxt_rdata = nfc_ff;
        `OFF_CCR0:    nxt_rdata = ccr_ff[0];
        `OFF_CCR1:    nxt_rdata = ccr_ff[1];
        `OFF_COUNT:   nxt_rdata = run ? count_ff : `CNT_READ_OFF;
        `OFF_STATUS:  nxt_rdata = {12'h0, status_ff};
        `OFF_MASK:    nxt_rdata = {12'h0, mask_ff};
        default:      nxt_rdata = 16'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl0_ff     <= 16'h0;
      ctrl1_ff     <= 16'h0;
      outctl_ff    <= 16'h0;
      capedge_ff   <= 16'h0;
      evtedge_ff   <= 16'h0;
      nfc_ff       <= 16'h0;
      ccr_ff[0]    <= `CCR_RST;
      ccr_ff[1]    <= `CCR_RST;
      shadow_ff[0] <= `CCR_RST;
      shadow_ff[1] <= `CCR_RST;
      status_ff    <= 4'h0;
      mask_ff      <= 4'h0;
      pre_ff       <= 3'h0;
      rdata        <= 16'h0;
      timer_out_0  <= 1'b0;
      timer_out_1  <= 1'b0;
      ext_trigger  <= 1'b0;
      match_irq_0  <= 1'b0;
      match_irq_1  <= 1'b0;
      irq          <= 1'b0;
    end else begin
      ctrl0_ff     <= nxt_ctrl0;
      ctrl1_ff     <= nxt_ctrl1;
      outctl_ff    <= nxt_outctl;
      capedge_ff   <= nxt_capedge;
      evtedge_ff   <= nxt_evtedge;
      nfc_ff       <= nxt_nfc;
      ccr_ff       <= nxt_ccr;
      shadow_ff    <= nxt_shadow;
      status_ff    <= nxt_status;
      mask_ff      <= nxt_mask;
      pre_ff       <= nxt_ctrl0[2:0];
      rdata        <= nxt_rdata;
      timer_out_0  <= nxt_tout[0];
      timer_out_1  <= nxt_tout[1];
      ext_trigger  <= nxt_trig;
      match_irq_0  <= ev[`ST_MATCH0];
      match_irq_1  <= ev[`ST_MATCH1];
      irq          <= |(nxt_status & nxt_mask);
    end
  end
endmodule // timer_compare_core
`default_nettype wire

// ---- include/timer_compare_defs.svh ----
// register offsets, field positions and reset values
// assumes a byte-addressed plain register port with 8-bit addresses
`ifndef TIMER_COMPARE_DEFS_SVH
`define TIMER_COMPARE_DEFS_SVH
`define OFF_CTRL0      8'h00
`define OFF_CTRL1      8'h04
`define OFF_OUTCTL     8'h08
`define OFF_CAPEDGE    8'h0c
`define OFF_EVTEDGE    8'h10
`define OFF_NFC        8'h14
`define OFF_CCR0       8'h18
`define OFF_CCR1       8'h1c
`define OFF_COUNT      8'h20
`define OFF_STATUS     8'h24
`define OFF_MASK       8'h28
`define CTRL0_RUN      7
`define CTRL1_EXT      0
`define CTRL1_CAP0     1
`define CTRL1_CAP1     2
`define NFC_LEN        3
`define CNT_HOLD       16'hffff
`define CNT_READ_OFF   16'h0000
`define CCR_RST        16'h0000
`define ST_MATCH0      0
`define ST_MATCH1      1
`define ST_CAP0        2
`define ST_CAP1        3
`endif

// ---- include/timer_compare_pkg.sv ----
// types shared by the timer core
package timer_compare_pkg;
  typedef enum logic [1:0] {
    edge_none    = 2'b00,
    edge_rise    = 2'b01,
    edge_fall    = 2'b10,
    edge_both    = 2'b11
  } edge_sel_t;
endpackage

// ---- verification/pin_stimulus.sv ----
// pin model for the two timer inputs
// assumes the bench calls pulse from its main thread; pins idle low
`timescale 1ns/1ns
`default_nettype none
module pin_stimulus (
  input  wire logic clk,
  output logic      pin_0,
  output logic      pin_1
);
  initial begin
    pin_0 = 1'b0;
    pin_1 = 1'b0;
  end
  // hi clocks high on the chosen pin; three or more always pass the two-flop synchroniser
  task automatic pulse(input int n, input int hi, input bit which);
    repeat (n) begin
      @(posedge clk);
      if (which) begin
        pin_1 <= 1'b1;
      end else begin
        pin_0 <= 1'b1;
      end
      repeat (hi) @(posedge clk);
      pin_0 <= 1'b0;
      pin_1 <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule // pin_stimulus
`default_nettype wire

// ---- verification/timer_compare_chk.sv ----
// port checker for the timer core
// assumes the register map of the shared defs header
`timescale 1ns/1ns
`default_nettype none
`include "timer_compare_defs.svh"
module timer_compare_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        match_irq_0,
  input wire logic        match_irq_1,
  input wire logic        irq
);
  logic        run_ff;
  logic [1:0]  cap_ff;
  logic [3:0]  mask_ff;
  logic [15:0] ccr0_ff;
  logic [15:0] ccr1_ff;
  // ==========================================
  // copies of software writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {run_ff, cap_ff, mask_ff, ccr0_ff, ccr1_ff} <= '0;
    end else if (wr) begin
      if (addr == `OFF_CTRL0) run_ff <= wdata[`CTRL0_RUN];
      // capture may reload the channels, so readback checks stop for good
      if (addr == `OFF_CTRL1) cap_ff <= cap_ff | wdata[2:1];
      if (addr == `OFF_MASK) mask_ff <= wdata[3:0];
      if (addr == `OFF_CCR0) ccr0_ff <= wdata;
      if (addr == `OFF_CCR1) ccr1_ff <= wdata;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rst; $rose(rst_n) |-> !irq && !match_irq_0 && !match_irq_1; endproperty
  a_rst: assert property (p_rst) else $error("output active out of reset");
  property p_cnt_off; rd && addr == `OFF_COUNT && !run_ff |=> rdata == `CNT_READ_OFF; endproperty
  a_cnt_off: assert property (p_cnt_off) else $error("count read not zero");
  property p_ccr0; rd && addr == `OFF_CCR0 && !cap_ff[0] |=> rdata == ccr0_ff; endproperty
  a_ccr0: assert property (p_ccr0) else $error("channel 0 readback");
  property p_ccr1; rd && addr == `OFF_CCR1 && !cap_ff[1] |=> rdata == ccr1_ff; endproperty
  a_ccr1: assert property (p_ccr1) else $error("channel 1 readback");
  property p_hole;
    rd && (addr > `OFF_MASK || addr[1:0] != 2'b00) |=> rdata == 16'h0000;
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  property p_pulse0; match_irq_0 |=> !match_irq_0; endproperty
  a_pulse0: assert property (p_pulse0) else $error("match 0 longer than a cycle");
  property p_pulse1; match_irq_1 |=> !match_irq_1; endproperty
  a_pulse1: assert property (p_pulse1) else $error("match 1 longer than a cycle");
  property p_irq_on; $rose(match_irq_0) && mask_ff[0] |-> ##[0:3] irq; endproperty
  a_irq_on: assert property (p_irq_on) else $error("unmasked match gave no irq");
  property p_irq_off;
    mask_ff == 4'h0 && $past(mask_ff) == 4'h0 && $past(mask_ff, 2) == 4'h0 |-> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while all masked");
endmodule // timer_compare_chk
bind timer_compare_core timer_compare_chk u_chk (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .match_irq_0(match_irq_0),
  .match_irq_1(match_irq_1), .irq(irq));
`default_nettype wire

// ---- verification/timer_compare_core_tb.sv ----
// self-checking bench for the timer core
// assumes pin model and checker compiled first; reads checked by a monitor
`timescale 1ns/1ns
`default_nettype none
`include "timer_compare_defs.svh"
module timer_compare_core_tb;
  logic        clk, rst_n, wr, rd, rd_prev;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, rnd, ev;
  logic        tin0, tin1, tout0, tout1, trig, m0, m1, irq;
  logic [15:0] exp_q[$];
  int          n_errors, tests_run, cyc;
  int          n_trig, n_m1;
  timer_compare_core DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .timer_in_0(tin0), .timer_in_1(tin1), .timer_out_0(tout0),
    .timer_out_1(tout1), .ext_trigger(trig), .match_irq_0(m0), .match_irq_1(m1), .irq(irq));
  pin_stimulus pins (.clk(clk), .pin_0(tin0), .pin_1(tin1));
  // ==========================================
  // tasks
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd   <= 1'b0;
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // read monitor: data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_prev <= rd;
    if (rd_prev) check(exp_q.size() > 0 && rdata === exp_q.pop_front(), "read data");
  end
  // one-cycle output pulses are counted while they stand
  always @(posedge clk) begin
    if (trig === 1'b1) n_trig++;
    if (m1 === 1'b1) n_m1++;
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  // ==========================================
  // main sequence
  initial begin
    {rst_n, wr, rd, addr, wdata} = '0;
    void'($urandom(54));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(`OFF_CCR0, `CCR_RST);
    rd_chk(`OFF_CCR1, `CCR_RST);
    rd_chk(`OFF_CTRL0, 16'h0000);
    rd_chk(`OFF_COUNT, `CNT_READ_OFF);
    rd_chk(8'h3c, 16'h0000);
    rnd = 16'($urandom);
    wr_reg(`OFF_CCR0, rnd);
    rd_chk(`OFF_CCR0, rnd);
    // filter set on pin 0 must not swallow event pulses shorter than it
    wr_reg(`OFF_NFC, 16'h0007);
    wr_reg(`OFF_CTRL1, 16'h0001);
    for (int m = 0; m < 4; m++) begin
      ev = (m == 0) ? 16'h0000 : (m == 3) ? 16'h0006 : 16'h0003;
      wr_reg(`OFF_CTRL0, 16'h0000);
      wr_reg(`OFF_EVTEDGE, {14'h0000, timer_compare_pkg::edge_sel_t'(m)});
      wr_reg(`OFF_CTRL0, 16'h0080);
      pins.pulse(3, 3, 1'b0);
      repeat (8) @(posedge clk);
      rd_chk(`OFF_COUNT, ev - 16'h0001);
    end
    wr_reg(`OFF_CTRL0, 16'h0000);
    wr_reg(`OFF_CTRL1, 16'h0000);
    wr_reg(`OFF_CCR0, 16'h0014);
    wr_reg(`OFF_CCR1, 16'h001e);
    wr_reg(`OFF_OUTCTL, 16'h0005);
    wr_reg(`OFF_MASK, 16'h0001);
    wr_reg(`OFF_CTRL0, 16'h0080);
    cyc = 0;
    while (m0 !== 1'b1 && cyc < 100) begin
      @(negedge clk);
      cyc++;
    end
    check(cyc >= 20 && cyc <= 24, "match 0 timing");
    rd_chk(`OFF_COUNT, 16'h0015);
    repeat (15) @(posedge clk);
    check(tout0 === 1'b1, "output 0 not toggled");
    check(tout1 === 1'b1, "output 1 not toggled");
    // three from the event loop, where shadow 1 still held zero, one at count 30
    check(n_m1 == 4, "match 1 pulse count");
    check(irq === 1'b1, "irq not raised");
    rd_chk(`OFF_STATUS, 16'h0003);
    wr_reg(`OFF_STATUS, 16'h0001);
    repeat (3) @(posedge clk);
    check(irq === 1'b0, "irq not cleared");
    rd_chk(`OFF_STATUS, 16'h0002);
    wr_reg(`OFF_CTRL0, 16'h0000);
    rd_chk(`OFF_COUNT, `CNT_READ_OFF);
    check(tout0 === 1'b0 && tout1 === 1'b0, "outputs not idle");
    // capture on pin 1 behind a 4-sample filter; pin 0 edges give triggers
    wr_reg(`OFF_STATUS, 16'h000f);
    wr_reg(`OFF_CTRL1, 16'h0004);
    wr_reg(`OFF_CAPEDGE, 16'h0004);
    wr_reg(`OFF_NFC, 16'h0040);
    wr_reg(`OFF_CTRL0, 16'h0080);
    pins.pulse(1, 3, 1'b1);
    pins.pulse(1, 3, 1'b0);
    repeat (30) @(posedge clk);
    rd_chk(`OFF_STATUS, 16'h0003);
    check(n_trig == 2, "external trigger count");
    pins.pulse(1, 8, 1'b1);
    repeat (8) @(posedge clk);
    rd_chk(`OFF_STATUS, 16'h000b);
    // divide by four: first tick on the fourth clock after run
    wr_reg(`OFF_CTRL0, 16'h0000);
    wr_reg(`OFF_CTRL0, 16'h0082);
    repeat (40) @(posedge clk);
    rd_chk(`OFF_COUNT, 16'h0009);
    repeat (2) @(posedge clk);
    give_verdict();
  end
endmodule // timer_compare_core_tb
`default_nettype wire
